/* File: dv/dac_load_model.sv */
`timescale 1ns/1ps
// Load on the two outputs; a disabled output rests at ground.
module dac_load_model
  import dac_ctrl_pkg::*;
(
  input dac_out_t ch0, // Channel 0 pin.
  input dac_out_t ch1, // Channel 1 pin.
  output logic [7:0] seen0, // Level on pin 0.
  output logic [7:0] seen1 // Level on pin 1.
);
  // No settling modelled, so the bench can sample with the valid flag.
  always_comb
  begin
    seen0 = ch0.valid ? ch0.code : 8'h00;
    seen1 = ch1.valid ? ch1.code : 8'h00;
  end
endmodule // dac_load_model

/* File: dv/dual_channel_dac_control_props.sv */
`timescale 1ns/1ps
module dac_ctrl_props
(
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic s_axi_awvalid, // Write address valid.
  input wire logic s_axi_awready, // Write address ready.
  input wire logic s_axi_wvalid, // Write data valid.
  input wire logic s_axi_wready, // Write data ready.
  input wire logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_arvalid, // Read address valid.
  input wire logic s_axi_arready, // Read address ready.
  input wire logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic [7:0] channel0_analog_out, // Code 0.
  input wire logic [7:0] channel1_analog_out, // Code 1.
  input wire logic channel0_valid, // Valid 0.
  input wire logic channel1_valid // Valid 1.
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // A disabled or unsettled output must not show a stale code.
  zero_code0_a: assert property (!channel0_valid |-> !channel0_analog_out)
    else $error("channel 0 code not zero while invalid");
  zero_code1_a: assert property (!channel1_valid |-> !channel1_analog_out)
    else $error("channel 1 code not zero while invalid");
  hold_code0_a: assert property (
    channel0_valid && $past(channel0_valid) |-> $stable(channel0_analog_out))
    else $error("channel 0 code moved while valid");
  hold_code1_a: assert property (
    channel1_valid && $past(channel1_valid) |-> $stable(channel1_analog_out))
    else $error("channel 1 code moved while valid");
  write_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid)
    else $error("read response late");
  one_write_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  ce_freeze_a: assert property (
    !ce |=> $stable(channel0_valid) && $stable(channel1_valid) &&
    $stable(channel0_analog_out) && $stable(channel1_analog_out))
    else $error("outputs moved with clock enable low");
  cover property ($rose(channel0_valid));
  cover property ($rose(channel1_valid));
  cover property (s_axi_rvalid && s_axi_rready);
endmodule // dac_ctrl_props
bind dual_channel_dac_control dac_ctrl_props u_props (.*);

/* File: dv/test_dual_channel_dac_control.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED at %0t got %h exp %h", $time, (a), (b)); end end
module test_dual_channel_dac_control
  import dac_ctrl_pkg::*;
;
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, standby = 1'h0;
  logic event_select_ch0 = 1'h0, event_select_ch1 = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, channel0_valid, channel1_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] channel0_analog_out, channel1_analog_out, seen0, seen1, d;
  int n_mismatch = 0, tests_run = 0, md[2] = '{0, 0}, ctl = 0, mst = 1;
  int sts = 0;
  dual_channel_dac_control dut (.*);
  dac_load_model load (.ch0({channel0_valid, channel0_analog_out}),
    .ch1({channel1_valid, channel1_analog_out}), .seen0(seen0),
    .seen1(seen1));
  always #2 aclk = ~aclk;
  // Reference model of the register file, kept in plain integers.
  function automatic logic [1:0] eresp(logic [23:0] i);
    if (i < CH0_DATA_IDX || i > STANDBY_IDX) return RESP_SLVERR;
    return (mst != 0 && i != STANDBY_IDX) ? RESP_SLVERR : RESP_OKAY;
  endfunction
  function automatic logic [31:0] erd(logic [23:0] i);
    if (i == CH0_DATA_IDX) return md[0];
    if (i == CH1_DATA_IDX) return md[1];
    if (i == CONTROL_IDX) return ctl;
    if (i == STATUS_IDX) return sts;
    return mst;
  endfunction
  task automatic wr(logic [23:0] i, logic [7:0] v);
    bit a, w;
    a = 1;
    w = 1;
    s_axi_awaddr <= {6'h00, i, 2'h0};
    s_axi_wdata <= {24'($urandom), v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (a || w)
    begin
      @(posedge aclk);
      if (a && s_axi_awready === 1'h1)
      begin
        a = 0;
        s_axi_awvalid <= 1'h0;
      end
      if (w && s_axi_wready === 1'h1)
      begin
        w = 0;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    `CHK(s_axi_bresp, eresp(i))
    // A refused or unstrobed write must leave the model untouched.
    if (eresp(i) == RESP_OKAY && s_axi_wstrb[0])
    begin
      if (i == CH0_DATA_IDX) md[0] = v;
      if (i == CH1_DATA_IDX) md[1] = v;
      if (i == CONTROL_IDX) ctl = v & 8'hc0;
      if (i == STANDBY_IDX) mst = v[0];
    end
  endtask
  task automatic rd(logic [23:0] i);
    s_axi_araddr <= {6'h00, i, 2'h0};
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    `CHK(s_axi_rresp, eresp(i))
    if (eresp(i) == RESP_OKAY) `CHK(s_axi_rdata, erd(i))
  endtask
  // Waits for a result and checks when it came and what it shows.
  task automatic conv(bit ch, logic [7:0] v, int lo);
    int n;
    n = 0;
    while ((ch ? channel1_valid : channel0_valid) !== 1'h1 && n < 2000)
    begin
      @(posedge aclk);
      n++;
    end
    `CHK(n >= lo && n <= CONV_CYCLES, 1'h1)
    `CHK(ch ? seen1 : seen0, v)
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog sized well above the three conversions the run needs.
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    summarize();
  end
  initial
  begin
    void'($urandom(68));
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(STANDBY_IDX);
    wr(CH0_DATA_IDX, 8'h5a);
    wr(STANDBY_IDX, 8'h00);
    rd(CH0_DATA_IDX);
    $display("module standby test done");
    for (int k = 0; k < 6; k++)
    begin
      wr(CH0_DATA_IDX + 24'(k % 2), 8'($urandom));
      rd(CH0_DATA_IDX + 24'(k % 2));
    end
    wr(CONTROL_IDX, 8'h3f);
    rd(CONTROL_IDX);
    wr(STANDBY_IDX + 24'h1, 8'h01);
    rd(STANDBY_IDX + 24'h1);
    s_axi_wstrb <= 4'he;
    wr(CH1_DATA_IDX, 8'h77);
    s_axi_wstrb <= 4'hf;
    rd(CH1_DATA_IDX);
    $display("register test done");
    d = 8'($urandom);
    wr(CH0_DATA_IDX, d);
    wr(CONTROL_IDX, 8'h40);
    conv(0, d, CONV_CYCLES - 8);
    `CHK(channel1_valid, 1'h0)
    d = 8'($urandom);
    wr(CH0_DATA_IDX, d);
    repeat (3) @(posedge aclk);
    `CHK(channel0_valid, 1'h0)
    conv(0, d, CONV_CYCLES - 8);
    wr(CONTROL_IDX, 8'h00);
    repeat (3) @(posedge aclk);
    `CHK(seen0, 8'h00)
    $display("channel 0 conversion test done");
    d = 8'($urandom);
    wr(CH1_DATA_IDX, d);
    event_select_ch1 <= 1'h1;
    @(posedge aclk);
    event_select_ch1 <= 1'h0;
    repeat (4) @(posedge aclk);
    ctl = 8'h80;
    rd(CONTROL_IDX);
    conv(1, d, CONV_CYCLES - 24);
    sts = 2;
    rd(STATUS_IDX);
    ce <= 1'h0;
    repeat (8) @(posedge aclk);
    ce <= 1'h1;
    `CHK(seen1, d)
    $display("event and clock enable test done");
    standby <= 1'h1;
    repeat (6) @(posedge aclk);
    standby <= 1'h0;
    repeat (6) @(posedge aclk);
    md = '{0, 0};
    rd(CH0_DATA_IDX);
    rd(CONTROL_IDX);
    wr(CH1_DATA_IDX, 8'($urandom));
    wr(STANDBY_IDX, 8'h01);
    wr(STANDBY_IDX, 8'h00);
    md = '{0, 0};
    rd(CH1_DATA_IDX);
    rd(CONTROL_IDX);
    event_select_ch0 <= 1'h1;
    @(posedge aclk);
    event_select_ch0 <= 1'h0;
    repeat (4) @(posedge aclk);
    ctl = 8'hc0;
    rd(CONTROL_IDX);
    wr(CONTROL_IDX, 8'h00);
    standby <= 1'h1;
    repeat (6) @(posedge aclk);
    `CHK(channel0_valid | channel1_valid, 1'h0)
    standby <= 1'h0;
    $display("standby test done");
    summarize();
  end
endmodule // test_dual_channel_dac_control

/* File: logic/conv_channel.sv */
`timescale 1ns/1ps
module conv_channel
  import dac_ctrl_pkg::*;
(
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic enable, // Channel output enable.
  input wire logic restart, // Data register was written.
  input wire logic [7:0] data, // Value to convert.
  output dac_out_t out // Converted code and valid flag.
);

  logic [CONV_CNT_W-1:0] cnt_q;
  logic busy_q;
  logic en_prev_q;
  dac_out_t out_q;

  // Conversion timer: a rising enable or a write while enabled restarts it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      en_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      en_prev_q <= enable;
      if (!enable)
      begin
        busy_q <= 1'b0;
      end
      else if (restart || !en_prev_q)
      begin
        busy_q <= 1'b1;
        // The start flop and the two output flops add three cycles, so
        // the load is shortened by them and the pin meets the worst case.
        cnt_q <= CONV_CNT_W'(CONV_CYCLES - CONV_PIPE);
      end
      else if (busy_q)
      begin
        if (cnt_q == '0)
          busy_q <= 1'b0;
        else
          cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // The output holds until a new write or the enable is dropped.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_q <= '0;
    end
    else if (ce)
    begin
      if (!enable || restart)
        out_q.valid <= 1'b0;
      else if (busy_q && cnt_q == '0)
      begin
        out_q.valid <= 1'b1;
        out_q.code <= data;
      end
    end
  end

  assign out = out_q;

endmodule // conv_channel

/* File: logic/dual_channel_dac_control.sv */
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
// Behaviour
// - Two channels convert their own 8-bit values independently.
// - Each channel has a readable and writable 8-bit data register.
// - Both data registers are zero while in standby or module standby.
// - Control bit 7 enables channel 1 conversion and output.
// - Control bit 6 enables channel 0 conversion and output.
// - Control bits 5 to 0 read as zero and ignore writes.
// - The control register keeps its value through either standby.
// - A linked event sets the matching channel enable bit outside module standby.
// - Setting an enable starts conversion, output valid after the time.
// - The result holds until a data write, module standby or the enable clears.
// - A data write while enabled restarts conversion at once.
// - Clearing an enable disables that channel output.
// - A result is ready within the maximum conversion time of 3 us.
// - The block starts in module standby; registers work after release.
module dual_channel_dac_control
  import dac_ctrl_pkg::*;
(
  input wire logic aclk, // Clock, 250 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic ce, // Clock enable; low freezes all state.
  input wire logic standby, // Device standby request, asynchronous.
  input wire logic event_select_ch0, // Event pulse for channel 0.
  input wire logic event_select_ch1, // Event pulse for channel 1.
  input wire logic [31:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [31:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic [7:0] channel0_analog_out, // Channel 0 code.
  output logic [7:0] channel1_analog_out, // Channel 1 code.
  output logic channel0_valid, // Channel 0 output valid.
  output logic channel1_valid // Channel 1 output valid.
);

  // Only the low address bits decode, so the map repeats higher up; a
  // narrow compare keeps the decoder small.
  localparam logic [ADDR_DEC_W-1:0] A_CH0 = ADDR_DEC_W'({CH0_DATA_IDX, 2'b00});
  localparam logic [ADDR_DEC_W-1:0] A_CH1 = ADDR_DEC_W'({CH1_DATA_IDX, 2'b00});
  localparam logic [ADDR_DEC_W-1:0] A_CTL = ADDR_DEC_W'({CONTROL_IDX, 2'b00});
  localparam logic [ADDR_DEC_W-1:0] A_STS = ADDR_DEC_W'({STATUS_IDX, 2'b00});
  localparam logic [ADDR_DEC_W-1:0] A_STB = ADDR_DEC_W'({STANDBY_IDX, 2'b00});

  // One-hot write sequencer: collect both halves, execute, answer.
  typedef enum logic [2:0] {
    W_IDLE = 3'b001,
    W_EXEC = 3'b010,
    W_RESP = 3'b100
  } wr_state_t;

  // Bus-side state, register file and converter outputs.
  wr_state_t wr_q;
  logic [ADDR_DEC_W-1:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] data_q [2];
  logic [1:0] en_q;
  logic mstby_q;
  logic [2:0] stby_sync_q;
  logic [1:0] evt0_sync_q;
  logic [1:0] evt1_sync_q;
  logic [1:0] data_wr;
  logic wr_ok;
  logic in_standby;
  logic [1:0] evt;
  dac_out_t ch_out [2];
  logic [7:0] code_q [2];
  logic [1:0] valid_q;
  logic ctl_wr;

  // Pin-level inputs pass two flops before use. Standby gets a third flop;
  // the extra cycle of lag is harmless for a power-mode request and keeps
  // every stage of the chain in use.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stby_sync_q <= '0;
      evt0_sync_q <= '0;
      evt1_sync_q <= '0;
    end
    else if (ce)
    begin
      stby_sync_q <= {stby_sync_q[1:0], standby};
      evt0_sync_q <= {evt0_sync_q[0], event_select_ch0};
      evt1_sync_q <= {evt1_sync_q[0], event_select_ch1};
    end
  end

  // Events are levels after sync; a held level just keeps the bit set.
  assign evt = {evt1_sync_q[1], evt0_sync_q[1]};
  assign in_standby = stby_sync_q[2] || mstby_q;

  // Write channel: address and data taken in either order, then executed.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_q <= W_IDLE;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (ce)
    begin
      case (wr_q)
        // Each ready drops at its own handshake, so either half may lead.
        W_IDLE:
        begin
          s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready);
          s_axi_wready <= !w_got_q && !(s_axi_wvalid && s_axi_wready);
          if (s_axi_awvalid && s_axi_awready)
          begin
            aw_got_q <= 1'b1;
            waddr_q <= s_axi_awaddr[ADDR_DEC_W-1:0];
          end
          if (s_axi_wvalid && s_axi_wready)
          begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
          end
          if ((aw_got_q || (s_axi_awvalid && s_axi_awready)) &&
              (w_got_q || (s_axi_wvalid && s_axi_wready)))
          begin
            wr_q <= W_EXEC;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
          end
        end
        // The decoded write lands at the end of this cycle.
        W_EXEC:
        begin
          aw_got_q <= 1'b0;
          w_got_q <= 1'b0;
          s_axi_bvalid <= 1'b1;
          s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
          wr_q <= W_RESP;
        end
        // Hold the response until the master takes it.
        W_RESP:
        begin
          if (s_axi_bready)
          begin
            s_axi_bvalid <= 1'b0;
            wr_q <= W_IDLE;
          end
        end
        default:
        begin
          wr_q <= W_IDLE;
        end
      endcase
    end
  end

  // Data and control registers are reachable only out of module standby.
  // Decoding happens in the execute state only, so a stale address is
  // harmless once the sequencer has moved on.
  always_comb
  begin
    wr_ok = 1'b0;
    data_wr = 2'b00;
    if (wr_q == W_EXEC)
    begin
      case (waddr_q)
        A_CH0:
        begin
          wr_ok = !mstby_q;
          data_wr[0] = !mstby_q && wstrb_q[0];
        end
        A_CH1:
        begin
          wr_ok = !mstby_q;
          data_wr[1] = !mstby_q && wstrb_q[0];
        end
        // Status is read-only: a write is answered but changes nothing.
        A_CTL, A_STS:
          wr_ok = !mstby_q;
        // Standby control stays reachable so the block can be woken.
        A_STB:
          wr_ok = 1'b1;
        default:
          wr_ok = 1'b0;
      endcase
    end
  end

  // Data registers, one per channel; standby clears them.
  // Standby beats a write in the same cycle, so a halted converter never
  // keeps a value.
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_data
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          data_q[i] <= DATA_RST;
        else if (ce)
        begin
          if (in_standby)
            data_q[i] <= DATA_RST;
          else if (data_wr[i])
            data_q[i] <= wdata_q[7:0];
        end
      end
    end
  endgenerate

  // Control write strobe, shared by the enable register below.
  assign ctl_wr = (wr_q == W_EXEC) && (waddr_q == A_CTL) && !mstby_q &&
    wstrb_q[0];

  // Enable bits survive both kinds of standby: device standby never reaches
  // this register, and module standby only holds it. A linked event wins
  // over a software clear in the same
  // cycle, so an event is never lost to a racing write.
  // Only bits 7 and 6 are stored; bits 5 to 0 have no flops to change.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      en_q <= CONTROL_RST[CH1_EN_BIT:CH0_EN_BIT];
    else if (ce)
    begin
      if (ctl_wr)
        en_q <= {wdata_q[CH1_EN_BIT], wdata_q[CH0_EN_BIT]} | evt;
      else if (!mstby_q)
        en_q <= en_q | evt;
    end
  end

  // Module standby bit: set from reset so the converter starts halted.
  // Writes to it are always accepted, even with the converter halted.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mstby_q <= MSTBY_RST;
    else if (ce && wr_q == W_EXEC && waddr_q == A_STB && wstrb_q[0])
      mstby_q <= wdata_q[MSTBY_BIT];
  end

  // Read channel answers one cycle after the address is taken. While the
  // converter is in module standby only the standby register answers;
  // every other access gets an error and no data.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        s_axi_rdata <= '0;
        case (s_axi_araddr[ADDR_DEC_W-1:0])
          A_CH0:
            if (mstby_q) s_axi_rresp <= RESP_SLVERR;
            else s_axi_rdata[7:0] <= data_q[0];
          A_CH1:
            if (mstby_q) s_axi_rresp <= RESP_SLVERR;
            else s_axi_rdata[7:0] <= data_q[1];
          A_CTL:
            if (mstby_q) s_axi_rresp <= RESP_SLVERR;
            else s_axi_rdata[7:0] <= {en_q, 6'h00};
          A_STS:
            if (mstby_q) s_axi_rresp <= RESP_SLVERR;
            else s_axi_rdata[1:0] <= valid_q;
          A_STB:
            s_axi_rdata[MSTBY_BIT] <= mstby_q;
          default:
            s_axi_rresp <= RESP_SLVERR;
        endcase
      end
    end
  end

  // Two independent converters; the output flops sit here.
  // Registering the pins keeps every top-level output on a flop; the cost
  // is one cycle, which the timer load already allows for.
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_conv
      conv_channel u_conv (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .enable(en_q[i] && !mstby_q),
        .restart(data_wr[i]),
        .data(data_q[i]),
        .out(ch_out[i])
      );

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          code_q[i] <= '0;
          valid_q[i] <= 1'b0;
        end
        else if (ce)
        begin
          code_q[i] <= ch_out[i].valid ? ch_out[i].code : 8'h00;
          valid_q[i] <= ch_out[i].valid;
        end
      end
    end
  endgenerate

  // Pins come straight from the output flops.
  assign channel0_analog_out = code_q[0];
  assign channel1_analog_out = code_q[1];
  assign channel0_valid = valid_q[0];
  assign channel1_valid = valid_q[1];

endmodule // dual_channel_dac_control

/* File: shared/dac_ctrl_pkg.sv */
package dac_ctrl_pkg;

  // Printed offsets are not multiples of four, so they are kept as indices.
  localparam logic [23:0] CH0_DATA_IDX = 24'hff05d4;
  localparam logic [23:0] CH1_DATA_IDX = 24'hff05d5;
  localparam logic [23:0] CONTROL_IDX = 24'hff05d6;
  localparam logic [23:0] STATUS_IDX = 24'hff05d7;
  localparam logic [23:0] STANDBY_IDX = 24'hff05d8;

  // Byte address is four times the index; only the low 12 bits decode.
  localparam int ADDR_DEC_W = 12;

  // Field positions.
  localparam int CH1_EN_BIT = 7;
  localparam int CH0_EN_BIT = 6;
  localparam int MSTBY_BIT = 0;

  // Reset values.
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic MSTBY_RST = 1'b1;

  // Conversion timing: 3 us worst case at a 4 ns clock.
  localparam int CONV_TIME_NS = 3000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int CONV_CNT_W = 10;
  // Cycles from a start to a raised valid pin beyond the timer itself.
  localparam int CONV_PIPE = 3;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Per-channel analog output view.
  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } dac_out_t;

endpackage
